// [hw/frrc_fault_ctrl.sv]
// module: fault response and retry controller with register port and interrupt
// What this block does
// - response code 10 turns output off, then follows retry-count field
// - response code 11 turns output off and latches it off until cleared
// - clear-faults command releases every latched fault
// - asserting the reset pin releases every latched fault
// - commanding output off then on (pin, operation, or both) releases latches
// - loss of bias power, the core reset, leaves no fault latched
// - clearing one status bit releases that fault's latch
// - retry count zero makes no restart attempt and keeps output off
// - retry codes one, two, three give that many restart attempts
// - when all attempts fail, output stays off until a clearing event
// - attempt starts are spaced by delay field times the delay unit
`timescale 1ns/100ps
module frrc_fault_ctrl #(
	parameter int N_FAULT  = frrc_pkg::NUM_FAULTS,
	parameter int UNIT_CYC = frrc_pkg::DELAY_UNIT_CYC
) (
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	input  wire logic [frrc_pkg::AW-1:0]   addr,
	input  wire logic [frrc_pkg::DW-1:0]   wr_data,
	input  wire logic                      wr_en,
	input  wire logic                      rd_en,
	output logic      [frrc_pkg::DW-1:0]   rd_data,
	input  wire logic [N_FAULT-1:0]        fault_pin,
	input  wire logic                      ctrl_pin,
	input  wire logic                      reset_pin_n,
	output logic                           pwr_enable,
	output logic      [N_FAULT-1:0]        fault_status,
	output logic                           irq
);
	import frrc_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [N_FAULT-1:0] fault_meta;
	logic [N_FAULT-1:0] fault_sync;
	logic               ctrl_meta;
	logic               ctrl_sync;
	logic               rstp_meta;
	logic               rstp_sync_n;
	logic               op_on;
	logic               on_prev;
	logic               on_cmd;
	logic               on_rise;
	logic               reset_req;
	logic               clear_cmd;
	logic               status_wr;
	logic               clear_all;
	logic [N_FAULT-1:0] clr_vec;
	logic [N_FAULT-1:0] eng_trip;
	logic [N_FAULT-1:0] eng_attempt;
	logic [N_FAULT-1:0] eng_off;
	logic [N_FAULT-1:0] eng_latched;
	logic [N_FAULT-1:0] irq_stat;
	logic [N_FAULT-1:0] irq_en;
	logic [N_FAULT-1:0] next_irq_stat;
	logic [N_FAULT-1:0] next_status;
	frrc_cfg_t          cfg [N_FAULT];

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fault_meta <= '0;
			fault_sync <= '0;
		end else begin
			fault_meta <= fault_pin;
			fault_sync <= fault_meta;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_meta   <= 1'h0;
			ctrl_sync   <= 1'h0;
			rstp_meta   <= 1'h1;
			rstp_sync_n <= 1'h1;
		end else begin
			ctrl_meta   <= ctrl_pin;
			ctrl_sync   <= ctrl_meta;
			rstp_meta   <= reset_pin_n;
			rstp_sync_n <= rstp_meta;
		end
	end

	// ----------------------------------------------------------------
	// clearing events
	// ----------------------------------------------------------------
	// the output is on only while both the pin and the operation bit say so
	assign on_cmd    = op_on && ctrl_sync;
	assign on_rise   = on_cmd && !on_prev;
	assign reset_req = !rstp_sync_n;
	assign clear_cmd = wr_en && (addr == ADDR_CLEAR);
	assign status_wr = wr_en && (addr == ADDR_STATUS);
	assign clear_all = clear_cmd || reset_req || on_rise;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			on_prev <= 1'h0;
		end else begin
			on_prev <= on_cmd;
		end
	end

	// ----------------------------------------------------------------
	// per-fault engines
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_FAULT; gi++) begin : g_fault
			// one status bit written as 1 releases only its own fault
			assign clr_vec[gi] = clear_all || (status_wr && wr_data[gi]);

			frrc_retry_engine #(
				.UNIT_CYC (UNIT_CYC)
			) u_engine (
				.core_clk (core_clk),
				.srst     (srst),
				.fault    (fault_sync[gi]),
				.cfg      (cfg[gi]),
				.clear    (clr_vec[gi]),
				.trip     (eng_trip[gi]),
				.attempt  (eng_attempt[gi]),
				.off      (eng_off[gi]),
				.latched  (eng_latched[gi])
			);

			always_ff @(posedge core_clk) begin
				if (srst) begin
					cfg[gi] <= CFG_RESET;
				end else if (wr_en && (addr == ADDR_CFG_BASE + AW'(gi))) begin
					cfg[gi] <= frrc_cfg_t'(wr_data);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// operation register and output enable
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			op_on <= OP_ON_RESET;
		end else if (wr_en && (addr == ADDR_OPERATION)) begin
			op_on <= wr_data[OP_ON_BIT];
		end
	end

	// any engine holding its fault off keeps the converter output down
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pwr_enable <= 1'h0;
		end else begin
			pwr_enable <= on_cmd && !(|eng_off);
		end
	end

	// ----------------------------------------------------------------
	// status and interrupt
	// ----------------------------------------------------------------
	// a trip in the same cycle as an interrupt clear survives: set wins; an engine never trips during its own clear
	assign next_status   = (fault_status & ~clr_vec) | eng_trip;
	assign next_irq_stat = (irq_stat & ~((wr_en && (addr == ADDR_IRQ_CLR)) ?
	                        wr_data[N_FAULT-1:0] : '0)) | eng_trip;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			fault_status <= '0;
		end else begin
			fault_status <= next_status;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_stat <= '0;
			irq_en   <= '0;
			irq      <= 1'h0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr_en && (addr == ADDR_IRQ_EN)) begin
				irq_en <= wr_data[N_FAULT-1:0];
			end
			irq <= |(next_irq_stat & irq_en);
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= '0;
			if (addr == ADDR_OPERATION) begin
				rd_data[OP_ON_BIT] <= op_on;
			end else if (addr == ADDR_STATUS) begin
				rd_data[N_FAULT-1:0] <= fault_status;
			end else if (addr == ADDR_IRQ_STAT) begin
				rd_data[N_FAULT-1:0] <= irq_stat;
			end else if (addr == ADDR_IRQ_EN) begin
				rd_data[N_FAULT-1:0] <= irq_en;
			end else begin
				for (int i = 0; i < N_FAULT; i++) begin
					if (addr == ADDR_CFG_BASE + AW'(i)) begin
						rd_data <= cfg[i];
					end
				end
			end
		end else begin
			rd_data <= '0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	logic [TIMER_W-1:0] gap0;
	logic [TIMER_W-1:0] load0;

	// helper: cycles since fault 0 tripped or last started an attempt
	assign load0 = TIMER_W'(cfg[0].delay) * TIMER_W'(UNIT_CYC);
	always_ff @(posedge core_clk) begin
		if (srst) begin
			gap0 <= '0;
		end else if (eng_trip[0] || eng_attempt[0]) begin
			gap0 <= TIMER_W'(1);
		end else if (gap0 != '1) begin
			gap0 <= gap0 + TIMER_W'(1);
		end
	end

	a_retry_code_off: assert property (
		eng_trip[0] && cfg[0].code == RESP_RETRY |=> eng_off[0] ##1 !pwr_enable)
		else $error("retry response did not switch output off");

	a_latch_code_hold: assert property (
		eng_trip[0] && cfg[0].code == RESP_LATCH && !clr_vec[0]
		|=> eng_latched[0] && !clr_vec[0] |=> eng_latched[0])
		else $error("latch response did not stay latched");

	a_clear_cmd_release: assert property (
		clear_cmd |=> eng_latched == '0)
		else $error("clear faults command left a latch set");

	a_reset_pin_release: assert property (
		$fell(rstp_sync_n) |=> eng_latched == '0)
		else $error("reset pin left a latch set");

	a_on_cycle_release: assert property (
		$rose(on_cmd) |=> eng_latched == '0)
		else $error("off then on command left a latch set");

	a_bias_loss_clean: assert property (
		@(posedge core_clk) disable iff (1'b0)
		srst |=> eng_latched == '0 && fault_status == '0 && !pwr_enable)
		else $error("latched state survived core reset");

	a_bit_clear_release: assert property (
		status_wr && wr_data[0] |=> !eng_latched[0] && !fault_status[0] || eng_trip[0])
		else $error("status bit clear left fault 0 latched");

	a_no_retry_latch: assert property (
		eng_trip[0] && cfg[0].code == RESP_RETRY && cfg[0].retries == RETRY_NONE
		|=> eng_latched[0] && !eng_attempt[0])
		else $error("zero retry count did not latch off");

	a_attempt_spacing: assert property (
		eng_attempt[0] && load0 != '0 |-> gap0 == load0 && cfg[0].retries != RETRY_NONE)
		else $error("restart attempt spacing wrong");

	a_fail_stays_off: assert property (
		$rose(eng_latched[0]) |-> ##1 !pwr_enable)
		else $error("output enabled after retries exhausted");

	a_latch_keeps_off: assert property (
		|eng_latched |=> !pwr_enable)
		else $error("a latched fault let the output back on");

	a_pwr_needs_on: assert property (
		!on_cmd |=> !pwr_enable)
		else $error("output enabled while commanded off");

	a_code_ignored: assert property (
		!cfg[0].code[1] |-> !eng_trip[0])
		else $error("fault with a passive response code tripped");

	a_status_set: assert property (
		eng_trip[0] |=> fault_status[0] && irq_stat[0])
		else $error("trip did not set its status bits");

	a_irq_level: assert property (
		!(wr_en && addr == ADDR_IRQ_EN) |=> irq == |(irq_stat & irq_en))
		else $error("interrupt level disagrees with enabled status");

	a_rd_idle_zero: assert property (
		!rd_en |=> rd_data == '0)
		else $error("read data not zero outside a read");

	logic [2:0] tries0;

	// helper: restart attempts since fault 0 last tripped, saturating
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tries0 <= '0;
		end else if (eng_trip[0]) begin
			tries0 <= '0;
		end else if (eng_attempt[0] && tries0 != '1) begin
			tries0 <= tries0 + 3'h1;
		end
	end

	a_attempt_limit: assert property (
		eng_attempt[0] |-> tries0 < RETRY_MAX && tries0 < cfg[0].retries)
		else $error("more restart attempts than the retry limit");

	// ----------------------------------------------------------------
	// per-fault release checks
	// ----------------------------------------------------------------
	// every source, not only fault 0, must drop its hold on a clear
	for (genvar ci = 0; ci < N_FAULT; ci++) begin : g_chk
		a_clear_to_idle: assert property (
			clr_vec[ci] |=> !eng_latched[ci] && !eng_off[ci])
			else $error("a clear left a fault source holding the output off");

		a_no_zero_try: assert property (
			eng_attempt[ci] |-> cfg[ci].retries != RETRY_NONE)
			else $error("restart attempt with retries set to zero");
	end

	c_retry_attempt: cover property (eng_attempt[0] ##[1:400] eng_attempt[0]);
	c_latch_then_clear: cover property (eng_latched[0] ##1 clear_cmd ##1 !eng_latched[0]);
	c_on_cycle: cover property (eng_latched[0] && on_rise);
	c_irq_fires: cover property ($rose(irq));
	c_retry_recover: cover property (eng_attempt[0] ##1 !eng_off[0] ##1 pwr_enable);

endmodule // frrc_fault_ctrl

// [hw/frrc_pkg.sv]
// package: constants, register map and carrier types of the fault response controller
package frrc_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_FAULTS = 4;
	localparam int AW         = 8;
	localparam int DW         = 8;
	localparam int TIMER_W    = 16;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] ADDR_OPERATION = 8'h00;
	localparam logic [AW-1:0] ADDR_CLEAR     = 8'h01;
	localparam logic [AW-1:0] ADDR_STATUS    = 8'h02;
	localparam logic [AW-1:0] ADDR_IRQ_STAT  = 8'h03;
	localparam logic [AW-1:0] ADDR_IRQ_CLR   = 8'h04;
	localparam logic [AW-1:0] ADDR_IRQ_EN    = 8'h05;
	localparam logic [AW-1:0] ADDR_CFG_BASE  = 8'h10;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int            OP_ON_BIT   = 0;
	localparam logic          OP_ON_RESET = 1'h1;
	localparam logic [DW-1:0] CFG_RESET   = 8'h00;
	localparam logic [1:0]    RESP_RETRY  = 2'h2;
	localparam logic [1:0]    RESP_LATCH  = 2'h3;
	localparam logic [2:0]    RETRY_NONE  = 3'h0;
	localparam logic [2:0]    RETRY_MAX   = 3'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ        = 50;
	localparam int DELAY_UNIT_NS  = 1000;
	localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// response byte: code on top, retry count, then delay count
	typedef struct packed {
		logic [1:0] code;
		logic [2:0] retries;
		logic [2:0] delay;
	} frrc_cfg_t;

endpackage

// [hw/frrc_retry_engine.sv]
// module: response sequencer for one fault source
`timescale 1ns/100ps
module frrc_retry_engine #(
	parameter int UNIT_CYC = frrc_pkg::DELAY_UNIT_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              fault,
	input  wire frrc_pkg::frrc_cfg_t cfg,
	input  wire logic              clear,
	output logic                   trip,
	output logic                   attempt,
	output logic                   off,
	output logic                   latched
);
	import frrc_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TRY, ST_LATCH} frrc_state_t;

	frrc_state_t          state;
	logic [TIMER_W-1:0]   timer;
	logic [1:0]           left;
	logic [TIMER_W-1:0]   load;
	logic [TIMER_W-1:0]   first;
	logic                 expire;
	logic [1:0]           capped;

	// interval counted as load cycles from one attempt start to the next
	assign load    = TIMER_W'(cfg.delay) * TIMER_W'(UNIT_CYC);
	assign first   = (load == '0) ? '0 : load - TIMER_W'(1);
	assign capped  = (cfg.retries > RETRY_MAX) ? RETRY_MAX[1:0] : cfg.retries[1:0];
	assign trip    = (state == ST_IDLE) && fault && cfg.code[1] && !clear;
	assign expire  = (timer == '0) && ((state == ST_WAIT) || ((state == ST_TRY) && fault));
	assign attempt = expire && (left != 2'h0) && !clear;
	assign off     = (state == ST_WAIT) || (state == ST_LATCH);
	assign latched = (state == ST_LATCH);

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= ST_IDLE;
			timer <= '0;
			left  <= 2'h0;
		end else if (clear) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (trip) begin
						if (cfg.code == RESP_LATCH || cfg.retries == RETRY_NONE) begin
							state <= ST_LATCH;
						end else begin
							state <= ST_WAIT;
							timer <= first;
							left  <= capped;
						end
					end
				end
				ST_WAIT, ST_TRY: begin
					if (expire) begin
						if (left == 2'h0) begin
							state <= ST_LATCH;
						end else begin
							state <= ST_TRY;
							timer <= first;
							left  <= left - 2'h1;
						end
					end else if (timer == '0) begin
						state <= ST_IDLE;
					end else begin
						timer <= timer - TIMER_W'(1);
						if (fault) begin
							state <= ST_WAIT;
						end
					end
				end
				ST_LATCH: begin
					state <= ST_LATCH;
				end
			endcase
		end
	end

endmodule // frrc_retry_engine

// [verif/frrc_host.sv]
// host-side register master model for the fault response controller
`timescale 1ns/100ps
module frrc_host (
	input  wire logic                    core_clk,
	output logic      [frrc_pkg::AW-1:0] addr,
	output logic      [frrc_pkg::DW-1:0] wr_data,
	output logic                         wr_en,
	output logic                         rd_en,
	input  wire logic [frrc_pkg::DW-1:0] rd_data
);
	import frrc_pkg::*;

	initial begin
		addr    = 8'h00;
		wr_data = 8'h00;
		wr_en   = 1'b0;
		rd_en   = 1'b0;
	end

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// released lines show the inverse so a stale value is never trusted
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge core_clk);
		wr_en   <= 1'b0;
		addr    <= ~a;
		wr_data <= ~d;
	endtask

	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge core_clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		addr  <= ~a;
		#1;
		d = rd_data;
	endtask

	// ----------------------------------------------------------------
	// fault release commands
	// ----------------------------------------------------------------
	task automatic clear_all();
		wr(ADDR_CLEAR, 8'h00);
	endtask

	task automatic clear_bit(input int i);
		wr(ADDR_STATUS, 8'(1 << i));
	endtask

	task automatic op_cycle();
		wr(ADDR_OPERATION, 8'h00);
		wr(ADDR_OPERATION, 8'h01);
	endtask
endmodule // frrc_host

// [verif/tb_frrc_fault_ctrl.sv]
// self-checking testbench of the fault response controller
`timescale 1ns/100ps
module tb_frrc_fault_ctrl;
	import frrc_pkg::*;
	// short delay unit keeps retry runs brief
	localparam int U   = 4;
	localparam int D   = 4;
	localparam int GAP = U * D;

	logic                  core_clk, srst, ctrl_pin, reset_pin_n;
	logic                  wr_en, rd_en, pwr_enable, irq;
	logic [AW-1:0]         addr;
	logic [DW-1:0]         wr_data, rd_data, rv;
	logic [NUM_FAULTS-1:0] fault_pin, fault_status;
	int                    n_mismatch, checks_done;

	frrc_fault_ctrl #(.N_FAULT(NUM_FAULTS), .UNIT_CYC(U)) uut (
		.core_clk(core_clk), .srst(srst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fault_pin(fault_pin),
		.ctrl_pin(ctrl_pin), .reset_pin_n(reset_pin_n), .pwr_enable(pwr_enable),
		.fault_status(fault_status), .irq(irq)
	);

	frrc_host host (
		.core_clk(core_clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic results();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wait_pwr(input logic v, input int lim);
		int i;
		for (i = 0; i < lim && pwr_enable !== v; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk(8'(pwr_enable), 8'(v));
		if (pwr_enable !== v) results();
	endtask

	task automatic stays_off(input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			if (pwr_enable !== 1'b0) bad = 1'b1;
		end
		chk(8'(bad), 8'h00);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		wait_pwr(1'b1, 10);
		host.rd(ADDR_OPERATION, rv);
		chk(rv, 8'h01);
		host.rd(ADDR_STATUS, rv);
		chk(rv, 8'h00);
		host.rd(8'h3F, rv);
		chk(rv, 8'h00);
	endtask

	// code 01 takes no action
	task automatic t_ignore();
		host.wr(ADDR_CFG_BASE + 8'h02, 8'h40);
		@(posedge core_clk);
		fault_pin[2] <= 1'b1;
		repeat (10) @(posedge core_clk);
		#1;
		chk(8'(pwr_enable), 8'h01);
		chk(8'(fault_status), 8'h00);
		fault_pin[2] <= 1'b0;
	endtask

	task automatic t_latch(input int m);
		host.wr(ADDR_CFG_BASE + 8'h01, 8'hC0);
		host.wr(ADDR_IRQ_EN, 8'h02);
		@(posedge core_clk);
		fault_pin[1] <= 1'b1;
		wait_pwr(1'b0, 10);
		@(posedge core_clk);
		fault_pin[1] <= 1'b0;
		chk(8'(irq), 8'h01);
		stays_off(4 * GAP);
		host.rd(ADDR_STATUS, rv);
		chk(rv & 8'h02, 8'h02);
		case (m)
			0: begin
				host.clear_all();
				wait_pwr(1'b1, 20);
			end
			1: begin
				@(posedge core_clk);
				reset_pin_n <= 1'b0;
				repeat (4) @(posedge core_clk);
				reset_pin_n <= 1'b1;
				wait_pwr(1'b1, 20);
			end
			2: begin
				host.clear_bit(1);
				wait_pwr(1'b1, 20);
				chk(8'(fault_status), 8'h00);
			end
			3: begin
				@(posedge core_clk);
				ctrl_pin <= 1'b0;
				repeat (4) @(posedge core_clk);
				ctrl_pin <= 1'b1;
				wait_pwr(1'b1, 20);
			end
			default: begin
				host.op_cycle();
				wait_pwr(1'b1, 20);
			end
		endcase
		host.wr(ADDR_IRQ_CLR, 8'h02);
		@(posedge core_clk);
		#1;
		chk(8'(irq), 8'h00);
	endtask

	// early release succeeds on the last attempt, late release stays latched
	task automatic t_retry(input int n, input bit early);
		host.wr(ADDR_CFG_BASE, {RESP_RETRY, 3'(n), 3'(D)});
		host.wr(ADDR_IRQ_EN, 8'h00);
		@(posedge core_clk);
		fault_pin[0] <= 1'b1;
		repeat (early ? n * GAP - 6 : (n + 1) * GAP - 6) @(posedge core_clk);
		fault_pin[0] <= 1'b0;
		if (early) begin
			wait_pwr(1'b1, GAP + 8);
		end else begin
			stays_off(3 * GAP);
			chk(8'(irq), 8'h00);
			host.clear_all();
			wait_pwr(1'b1, 20);
		end
		repeat (2 * GAP) @(posedge core_clk);
	endtask

	task automatic t_power_loss();
		host.wr(ADDR_CFG_BASE + 8'h01, 8'hC0);
		@(posedge core_clk);
		fault_pin[1] <= 1'b1;
		wait_pwr(1'b0, 10);
		@(posedge core_clk);
		fault_pin[1] <= 1'b0;
		srst         <= 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		wait_pwr(1'b1, 10);
		chk(8'(fault_status), 8'h00);
		host.rd(ADDR_CFG_BASE + 8'h01, rv);
		chk(rv, CFG_RESET);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_mismatch  = 0;
		checks_done = 0;
		srst        = 1'b1;
		fault_pin   = 4'h0;
		ctrl_pin    = 1'b1;
		reset_pin_n = 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_ignore();
		for (int m = 0; m < 5; m++) t_latch(m);
		for (int n = 0; n < 4; n++) t_retry(n, 1'b0);
		for (int n = 1; n < 4; n++) t_retry(n, 1'b1);
		// retry codes above three are held to three attempts
		t_retry(5, 1'b0);
		t_power_loss();
		results();
	end
endmodule // tb_frrc_fault_ctrl
